// ==== hw/nmcs_pkg.sv ====
package nmcs_pkg;

   // ************************************************
   // register map (16-bit registers, index addressed)
   // ************************************************
   localparam logic [3:0]  REG_CTRL       = 4'h0;
   localparam logic [3:0]  REG_CFG        = 4'h1;
   localparam logic [3:0]  REG_STAT       = 4'h2;
   localparam logic [3:0]  REG_ECC0       = 4'h4;
   localparam logic [3:0]  REG_ECCL       = 4'hb;
   localparam logic [15:0] CTRL_RST       = 16'h0001;
   localparam logic [15:0] CFG_RST        = 16'h0000;
   localparam logic [15:0] CFG_MASK       = 16'h0ff7;
   localparam int          CTRL_START_LSB = 8;
   localparam int          CFG_BYTE_BIT   = 2;
   localparam int          CFG_SSTRB_LSB  = 4;
   localparam int          CFG_EW_LSB     = 8;
   localparam logic [1:0]  BUS8           = 2'h0;

   // ************************************************
   // address map and ecc limits
   // ************************************************
   localparam logic [2:0]  SPACE_FIRST    = 3'h1;
   localparam logic [2:0]  SPACE_LAST     = 3'h4;
   localparam logic [9:0]  ECC_MAX        = 10'h200;

   // ************************************************
   // async cycle phase lengths in clk cycles
   // ************************************************
   localparam logic [2:0]  SETUP_CYC      = 3'h1;
   localparam logic [2:0]  STROBE_CYC     = 3'h2;
   localparam logic [2:0]  HOLD_CYC       = 3'h1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_SETUP = 4'h2,
      ST_STRB  = 4'h4,
      ST_HOLD  = 4'h8
   } nmcs_state_t;

   typedef struct packed {
      logic        hit;
      logic        we;
      logic        dma;
      logic        two;
      logic [1:0]  space;
      logic [20:0] addr;
      logic [1:0]  ba;
      logic [15:0] data;
   } nmcs_req_t;

endpackage : nmcs_pkg

// ==== hw/nmcs_ctrl.sv ====
`timescale 1ns/1ps

// ************************************************
// request fifo
// ************************************************
module nmcs_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 4
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [W-1:0]           in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [W-1:0]                out_data,
   output logic [$clog2(D):0]          level
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic [AW:0]   cnt_d;
   logic          push;
   logic          pop;

   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   assign out_data = mem_q[rp_q];
   assign level    = cnt_q;

   always_comb begin
      cnt_d = cnt_q;
      if (push & ~pop) cnt_d = cnt_q + 1'b1;
      if (pop & ~push) cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q] <= in_data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
         if (pop) rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
         cnt_q     <= cnt_d;
         in_ready  <= (cnt_d != (AW + 1)'(D));
         out_valid <= (cnt_d != '0);
      end
   end
endmodule : nmcs_fifo

// ************************************************
// flash mode select space controller
// ************************************************
module nmcs_ctrl #(
   parameter int unsigned FD = 4
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   input  wire logic        cpu_valid,
   input  wire logic        cpu_we,
   input  wire logic [24:0] cpu_addr,
   input  wire logic [15:0] cpu_wdata,
   output logic             cpu_ready,
   input  wire logic        dma_valid,
   input  wire logic        dma_we,
   input  wire logic [25:0] dma_addr,
   input  wire logic [15:0] dma_wdata,
   output logic             dma_ready,
   output logic             rd_valid,
   output logic [15:0]      rd_data,
   output logic             rd_from_dma,
   output logic [3:0]       ext_chip_select_n,
   output logic [20:0]      ext_address_pins,
   output logic [1:0]       ext_bank_pins,
   output logic             ext_oe_n,
   output logic             ext_we_n,
   output logic [15:0]      ext_data_o,
   output logic             ext_data_oe,
   input  wire logic [15:0] ext_data_i
);
   localparam int RW = $bits(nmcs_pkg::nmcs_req_t);

   logic [3:0]            use_q;
   logic [3:0]            start_q;
   logic [15:0]           cfg_q;
   logic [23:0]           ecc_q [4];
   logic [9:0]            bcnt_q [4];
   nmcs_pkg::nmcs_state_t st_q;
   logic [2:0]            tmr_q;
   logic                  beat_q;
   nmcs_pkg::nmcs_req_t   cur_q;
   nmcs_pkg::nmcs_req_t   req_in;
   nmcs_pkg::nmcs_req_t   f_out;
   logic                  f_in_ready;
   logic                  f_out_valid;
   logic [$clog2(FD):0]   f_level;
   logic                  bus8;
   logic                  xfer;
   logic [7:0]            xb0;
   logic [7:0]            xb1;
   logic [2:0]            sp_c;
   logic [2:0]            sp_d;
   logic [3:0]            ecc_off;

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [2:0] nmcs_space(input logic [2:0] hi);
      logic [2:0] d;
      d = hi - nmcs_pkg::SPACE_FIRST;
      return {(hi >= nmcs_pkg::SPACE_FIRST) &&
              (hi <= nmcs_pkg::SPACE_LAST), d[1:0]};
   endfunction : nmcs_space

   function automatic logic [3:0] nmcs_sel(input logic [1:0] sp);
      return ~(4'h1 << sp);
   endfunction : nmcs_sel

   function automatic logic [1:0] nmcs_ba(input nmcs_pkg::nmcs_req_t r,
                                          input logic b,
                                          input logic b8);
      return {r.ba[1], b8 & (r.ba[0] | b)};
   endfunction : nmcs_ba

   // column parities in [5:0], row parities by byte index in [23:6]
   function automatic logic [23:0] nmcs_ecc_upd(input logic [23:0] e,
                                                input logic [7:0]  b,
                                                input logic [8:0]  idx);
      logic [23:0] r;
      logic [7:0]  m;
      logic        bp;
      r  = e;
      bp = ^b;
      for (int k = 0; k < 3; k++) begin
         m = (k == 0) ? 8'haa : (k == 1) ? 8'hcc : 8'hf0;
         r[2*k+1] = r[2*k+1] ^ (^(b & m));
         r[2*k]   = r[2*k] ^ (^(b & ~m));
      end
      for (int j = 0; j < 9; j++) begin
         if (idx[j]) r[7+2*j] = r[7+2*j] ^ bp;
         else r[6+2*j] = r[6+2*j] ^ bp;
      end
      return r;
   endfunction : nmcs_ecc_upd

   // ************************************************
   // request capture into the fifo
   // ************************************************
   assign bus8 = (cfg_q[1:0] == nmcs_pkg::BUS8);
   assign sp_c = nmcs_space(cpu_addr[24:22]);
   assign sp_d = nmcs_space(dma_addr[25:23]);

   always_comb begin
      req_in = '0;
      if (cpu_valid) begin
         req_in.hit   = sp_c[2];
         req_in.we    = cpu_we;
         req_in.space = sp_c[1:0];
         req_in.two   = bus8 & ~cfg_q[nmcs_pkg::CFG_BYTE_BIT];
         req_in.addr  = cpu_addr[21:1];
         req_in.ba    = {cpu_addr[0], 1'b0};
         req_in.data  = cpu_wdata;
      end else begin
         req_in.hit   = sp_d[2];
         req_in.we    = dma_we;
         req_in.dma   = 1'b1;
         req_in.space = sp_d[1:0];
         req_in.two   = bus8;
         // address passes straight through: no hold-address mode
         req_in.addr  = dma_addr[22:2];
         req_in.ba    = dma_addr[1:0];
         req_in.data  = dma_wdata;
      end
   end

   assign cpu_ready = f_in_ready;
   assign dma_ready = f_in_ready;

   nmcs_fifo #(.W(RW), .D(FD)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (cpu_valid | dma_valid),
      .in_ready  (f_in_ready),
      .in_data   (req_in),
      .out_valid (f_out_valid),
      .out_ready (st_q == nmcs_pkg::ST_IDLE),
      .out_data  (f_out),
      .level     (f_level)
   );

   // ************************************************
   // control and configuration registers
   // ************************************************
   assign ecc_off = reg_addr - nmcs_pkg::REG_ECC0;

   always_ff @(posedge clk) begin
      if (rst) begin
         use_q   <= nmcs_pkg::CTRL_RST[3:0];
         start_q <= nmcs_pkg::CTRL_RST[11:8];
         cfg_q   <= nmcs_pkg::CFG_RST;
      end else if (reg_wr && reg_addr == nmcs_pkg::REG_CTRL) begin
         use_q   <= reg_wdata[3:0];
         start_q <= reg_wdata[11:8];
      end else if (reg_wr && reg_addr == nmcs_pkg::REG_CFG) begin
         cfg_q   <= reg_wdata & nmcs_pkg::CFG_MASK;
      end else if (reg_rd && reg_addr >= nmcs_pkg::REG_ECC0 &&
                   reg_addr <= nmcs_pkg::REG_ECCL) begin
         start_q[ecc_off[2:1]] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            nmcs_pkg::REG_CTRL: reg_rdata <= {4'h0, start_q, 4'h0, use_q};
            nmcs_pkg::REG_CFG:  reg_rdata <= cfg_q;
            nmcs_pkg::REG_STAT: reg_rdata <= {~st_q[0], 11'h000,
                                              4'(f_level)};
            default: begin
               if (reg_addr >= nmcs_pkg::REG_ECC0 &&
                   reg_addr <= nmcs_pkg::REG_ECCL)
                  reg_rdata <= ecc_off[0] ?
                               {8'h00, ecc_q[ecc_off[2:1]][23:16]} :
                               ecc_q[ecc_off[2:1]][15:0];
               else
                  reg_rdata <= 16'h0000;
            end
         endcase
      end
   end

   // ************************************************
   // one async cycle per request, two for a word on the 8-bit bus, select released after
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q              <= nmcs_pkg::ST_IDLE;
         tmr_q             <= '0;
         beat_q            <= 1'b0;
         cur_q             <= '0;
         ext_chip_select_n <= 4'hf;
         ext_address_pins  <= '0;
         ext_bank_pins     <= '0;
         ext_oe_n          <= 1'b1;
         ext_we_n          <= 1'b1;
         ext_data_o        <= '0;
         ext_data_oe       <= 1'b0;
         rd_valid          <= 1'b0;
         rd_data           <= '0;
         rd_from_dma       <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         case (st_q)
            nmcs_pkg::ST_IDLE: begin
               if (f_out_valid) begin
                  cur_q            <= f_out;
                  beat_q           <= 1'b0;
                  st_q             <= nmcs_pkg::ST_SETUP;
                  tmr_q            <= nmcs_pkg::SETUP_CYC;
                  ext_address_pins <= f_out.addr;
                  ext_bank_pins    <= nmcs_ba(f_out, 1'b0, bus8);
                  ext_data_o       <= f_out.data;
                  ext_data_oe      <= f_out.we;
                  // normal strobe mode drives select from setup on
                  if (f_out.hit &&
                      !cfg_q[nmcs_pkg::CFG_SSTRB_LSB + f_out.space])
                     ext_chip_select_n <= nmcs_sel(f_out.space);
               end
            end
            nmcs_pkg::ST_SETUP: begin
               if (tmr_q == 3'h1) begin
                  st_q     <= nmcs_pkg::ST_STRB;
                  tmr_q    <= nmcs_pkg::STROBE_CYC;
                  ext_oe_n <= cur_q.we;
                  ext_we_n <= ~cur_q.we;
                  if (cur_q.hit)
                     ext_chip_select_n <= nmcs_sel(cur_q.space);
               end else begin
                  tmr_q <= tmr_q - 3'h1;
               end
            end
            nmcs_pkg::ST_STRB: begin
               if (tmr_q == 3'h1) begin
                  st_q     <= nmcs_pkg::ST_HOLD;
                  tmr_q    <= nmcs_pkg::HOLD_CYC;
                  ext_oe_n <= 1'b1;
                  ext_we_n <= 1'b1;
                  if (cfg_q[nmcs_pkg::CFG_SSTRB_LSB + cur_q.space])
                     ext_chip_select_n <= 4'hf;
                  if (!cur_q.we) begin
                     if (cur_q.two && beat_q)
                        rd_data[15:8] <= ext_data_i[7:0];
                     else if (cur_q.two || bus8)
                        rd_data <= {8'h00, ext_data_i[7:0]};
                     else
                        rd_data <= ext_data_i;
                  end
               end else begin
                  tmr_q <= tmr_q - 3'h1;
               end
            end
            nmcs_pkg::ST_HOLD: begin
               if (tmr_q != 3'h1) begin
                  tmr_q <= tmr_q - 3'h1;
               end else if (cur_q.two && !beat_q) begin
                  // upper byte of an 8-bit bus word, no turnaround
                  beat_q        <= 1'b1;
                  st_q          <= nmcs_pkg::ST_SETUP;
                  tmr_q         <= nmcs_pkg::SETUP_CYC;
                  ext_bank_pins <= nmcs_ba(cur_q, 1'b1, bus8);
                  ext_data_o    <= {8'h00, cur_q.data[15:8]};
               end else begin
                  st_q              <= nmcs_pkg::ST_IDLE;
                  ext_chip_select_n <= 4'hf;
                  ext_data_oe       <= 1'b0;
                  rd_valid          <= ~cur_q.we;
                  rd_from_dma       <= cur_q.dma;
               end
            end
            default: st_q <= nmcs_pkg::ST_IDLE;
         endcase
      end
   end

   // ************************************************
   // 1-bit ecc accumulation per select space
   // ************************************************
   assign xfer = (st_q == nmcs_pkg::ST_STRB) && (tmr_q == 3'h1);
   assign xb0  = cur_q.we ? ext_data_o[7:0] : ext_data_i[7:0];
   assign xb1  = cur_q.we ? ext_data_o[15:8] : ext_data_i[15:8];

   always_ff @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (rst) begin
            ecc_q[i]  <= '0;
            bcnt_q[i] <= '0;
         end else if (reg_wr && reg_addr == nmcs_pkg::REG_CTRL &&
                      reg_wdata[nmcs_pkg::CTRL_START_LSB + i]) begin
            ecc_q[i]  <= '0;
            bcnt_q[i] <= '0;
         end else if (xfer && cur_q.hit && cur_q.space == 2'(i) &&
                      use_q[i] && start_q[i] &&
                      bcnt_q[i] < nmcs_pkg::ECC_MAX) begin
            if (bus8) begin
               ecc_q[i]  <= nmcs_ecc_upd(ecc_q[i], xb0, bcnt_q[i][8:0]);
               bcnt_q[i] <= bcnt_q[i] + 10'h001;
            end else begin
               ecc_q[i]  <= nmcs_ecc_upd(
                               nmcs_ecc_upd(ecc_q[i], xb0, bcnt_q[i][8:0]),
                               xb1, bcnt_q[i][8:0] + 9'h001);
               bcnt_q[i] <= bcnt_q[i] + 10'h002;
            end
         end
      end
   end

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge clk); endclocking

   a_cs_idle_high: assert property (disable iff (rst)
      st_q == nmcs_pkg::ST_IDLE |-> ext_chip_select_n == 4'hf)
      else $error("select low while idle");
   a_reset_mode: assert property (
      rst |=> use_q == 4'h1 && start_q == 4'h0)
      else $error("wrong flash mode after reset");
   a_ecc_clear: assert property (disable iff (rst)
      reg_wr && reg_addr == nmcs_pkg::REG_CTRL && reg_wdata[8]
      |=> ecc_q[0] == 24'h0 && bcnt_q[0] == 10'h0)
      else $error("ecc not cleared by start");
   a_start_read: assert property (disable iff (rst)
      reg_rd && reg_addr == nmcs_pkg::REG_ECC0 |=> !start_q[0])
      else $error("ecc read left start set");
   a_bank0_wide: assert property (disable iff (rst)
      st_q == nmcs_pkg::ST_SETUP && $past(st_q) == nmcs_pkg::ST_IDLE &&
      $past(cfg_q[1:0]) != nmcs_pkg::BUS8 |-> !ext_bank_pins[0])
      else $error("bank pin 0 driven on wide bus");
   a_ecc_gated: assert property (disable iff (rst)
      !use_q[1] && !(reg_wr && reg_addr == nmcs_pkg::REG_CTRL)
      |=> ecc_q[1] == $past(ecc_q[1]))
      else $error("ecc moved in plain space");
   a_ecc_limit: assert property (disable iff (rst)
      bcnt_q[2] <= nmcs_pkg::ECC_MAX)
      else $error("ecc byte count past limit");
   a_cs_onehot: assert property (disable iff (rst)
      $onehot0(~ext_chip_select_n))
      else $error("more than one select active");
   a_strobe_len: assert property (disable iff (rst)
      $fell(ext_oe_n) |-> !ext_oe_n ##1 !ext_oe_n ##1 ext_oe_n)
      else $error("read strobe length wrong");

endmodule : nmcs_ctrl

// ==== sim/nmcs_flash_model.sv ====
`timescale 1ns/1ps

// ************************************************
// flash device on the far side of the pins
// ************************************************
module nmcs_flash_model #(
   parameter int unsigned AW = 4
) (
   input  wire logic [3:0]  sel_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        wp_n,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] din,
   output logic [15:0]      dout
);
   logic [15:0] mem [2**AW];
   logic [15:0] last_q = 16'h0000;

   // each selected single cycle is latched on its own write strobe
   always @(posedge we_n) begin
      if (sel_n != 4'hf && wp_n) begin
         mem[addr[AW-1:0]] <= din;
      end
   end

   always @(posedge oe_n) begin
      last_q <= mem[addr[AW-1:0]];
   end

   // a released bus never shows the last value
   assign dout = (sel_n != 4'hf && !oe_n) ? mem[addr[AW-1:0]] : ~last_q;
endmodule : nmcs_flash_model

// ==== sim/nand_mode_chip_select_control_tb_top.sv ====
`timescale 1ns/1ps

module nand_mode_chip_select_control_tb_top;
   typedef struct packed {
      logic        dma;
      logic [25:0] a;
      logic [3:0]  cs;
      logic [20:0] pa;
      logic [1:0]  ba;
   } nmcs_row_t;

   logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        cpu_valid = 1'b0, cpu_we = 1'b0, dma_valid = 1'b0;
   logic        dma_we = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0, cpu_wdata = 16'h0, dma_wdata = 16'h0;
   logic [24:0] cpu_addr = 25'h0;
   logic [25:0] dma_addr = 26'h0;
   logic [15:0] reg_rdata, rd_data, ext_data_o, ext_data_i, rv;
   logic        cpu_ready, dma_ready, rd_valid, rd_from_dma;
   logic        ext_oe_n, ext_we_n, ext_data_oe, doe;
   logic [3:0]  ext_chip_select_n, cs;
   logic [20:0] ext_address_pins, pa;
   logic [1:0]  ext_bank_pins, ba;
   int          n_errors = 0, n_tests = 0, sel_cnt = 0, acc, i;
   int          lo_cnt = 0;

   nmcs_row_t rows [9] = '{
      '{1'b0, 26'h0400000, 4'he, 21'h000000, 2'h0},
      '{1'b0, 26'h0402000, 4'he, 21'h001000, 2'h0},
      '{1'b0, 26'h0401001, 4'he, 21'h000800, 2'h2},
      '{1'b0, 26'h0bfffff, 4'hd, 21'h1fffff, 2'h2},
      '{1'b0, 26'h0c00000, 4'hb, 21'h000000, 2'h0},
      '{1'b0, 26'h1000000, 4'h7, 21'h000000, 2'h0},
      '{1'b1, 26'h0800003, 4'he, 21'h000000, 2'h2},
      '{1'b1, 26'h0c00006, 4'he, 21'h100001, 2'h2},
      '{1'b1, 26'h1000004, 4'hd, 21'h000001, 2'h0}};

   nmcs_ctrl uut (
      .clk               (clk),
      .rst               (rst),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata         (reg_rdata),
      .cpu_valid         (cpu_valid),
      .cpu_we            (cpu_we),
      .cpu_addr          (cpu_addr),
      .cpu_wdata         (cpu_wdata),
      .cpu_ready         (cpu_ready),
      .dma_valid         (dma_valid),
      .dma_we            (dma_we),
      .dma_addr          (dma_addr),
      .dma_wdata         (dma_wdata),
      .dma_ready         (dma_ready),
      .rd_valid          (rd_valid),
      .rd_data           (rd_data),
      .rd_from_dma       (rd_from_dma),
      .ext_chip_select_n (ext_chip_select_n),
      .ext_address_pins  (ext_address_pins),
      .ext_bank_pins     (ext_bank_pins),
      .ext_oe_n          (ext_oe_n),
      .ext_we_n          (ext_we_n),
      .ext_data_o        (ext_data_o),
      .ext_data_oe       (ext_data_oe),
      .ext_data_i        (ext_data_i)
   );

   nmcs_flash_model flash (
      .sel_n (ext_chip_select_n),
      .oe_n  (ext_oe_n),
      .we_n  (ext_we_n),
      .wp_n  (1'b1),
      .addr  (ext_address_pins),
      .din   (ext_data_o),
      .dout  (ext_data_i)
   );

   always #12.5 clk = ~clk;

   always @(negedge ext_chip_select_n[0]) sel_cnt++;

   // cycles with select 0 low, seen at each rising edge
   always @(posedge clk) begin
      if (ext_chip_select_n[0] === 1'b0) lo_cnt++;
   end

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic tally_and_finish;
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic hang;
      n_errors++;
      tally_and_finish();
   endtask : hang

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : reg_read

   task automatic req(input logic d, input logic w, input logic [25:0] a,
                      input logic [15:0] wd);
      int k;
      cpu_valid <= !d;
      dma_valid <= d;
      cpu_we <= w;
      dma_we <= w;
      cpu_addr <= a[24:0];
      dma_addr <= a;
      cpu_wdata <= wd;
      dma_wdata <= wd;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (cpu_ready === 1'b1) break;
      end
      if (k == 20) hang();
      cpu_valid <= 1'b0;
      dma_valid <= 1'b0;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (ext_chip_select_n !== 4'hf) break;
      end
      if (k == 20) hang();
      cs = ext_chip_select_n;
      pa = ext_address_pins;
      ba = ext_bank_pins;
      doe = ext_data_oe;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (rd_valid === 1'b1) rv = rd_data;
         if (w ? ext_chip_select_n === 4'hf : rd_valid === 1'b1) break;
      end
      if (k == 20) hang();
   endtask : req

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      reg_read(4'h0, rv);
      check(rv, 16'h0001);
      reg_read(4'h1, rv);
      check(rv, 16'h0000);
      reg_write(4'h0, 16'h0005);
      reg_write(4'hf, 16'hffff);
      reg_read(4'hf, rv);
      check(rv, 16'h0000);
      reg_read(4'h0, rv);
      check(rv, 16'h0005);
      reg_write(4'h1, 16'h0001);
      for (i = 0; i < 9; i++) begin
         req(rows[i].dma, 1'b1, rows[i].a, 16'(i));
         check({cs, pa, ba}, rows[i][26:0]);
         check(doe, 1'b1);
      end
      req(1'b0, 1'b1, 26'h0400002, 16'h1234);
      lo_cnt = 0;
      req(1'b0, 1'b0, 26'h0400002, 16'h0000);
      check(rv, 16'h1234);
      check(lo_cnt, 4);
      req(1'b1, 1'b0, 26'h0800004, 16'h0000);
      check({rd_from_dma, rv}, {1'b1, 16'h1234});
      // select strobe mode: select low only during the strobe
      reg_write(4'h1, 16'h0011);
      lo_cnt = 0;
      req(1'b0, 1'b0, 26'h0400002, 16'h0000);
      check(rv, 16'h1234);
      check(lo_cnt, 2);
      reg_write(4'h1, 16'h0004);
      req(1'b0, 1'b0, 26'h0400002, 16'h0000);
      check(rv, 16'h0034);
      // 8-bit bus word: two beats, bank pin 0 in use
      reg_write(4'h1, 16'h0000);
      req(1'b0, 1'b0, 26'h0400002, 16'h0000);
      check(rv, 16'h3434);
      req(1'b1, 1'b1, 26'h0800003, 16'h0000);
      check(ba, 2'h3);
      reg_write(4'h1, 16'h0001);
      // ecc start, accumulate, read clears start, restart clears result
      reg_write(4'h0, 16'h0101);
      req(1'b0, 1'b1, 26'h0400000, 16'h0001);
      reg_read(4'h4, rv);
      check(rv, 16'h5555);
      reg_read(4'h5, rv);
      check(rv, 16'h0055);
      reg_read(4'h0, rv);
      check(rv, 16'h0001);
      reg_write(4'h0, 16'h0101);
      reg_read(4'h4, rv);
      check(rv, 16'h0000);
      reg_write(4'h0, 16'h0300);
      req(1'b0, 1'b1, 26'h0400000, 16'h0001);
      req(1'b0, 1'b1, 26'h0800000, 16'h0001);
      reg_read(4'h4, rv);
      check(rv, 16'h0000);
      reg_read(4'h6, rv);
      check(rv, 16'h0000);
      // fill the request queue until it refuses, then drain
      sel_cnt = 0;
      acc = 0;
      cpu_valid <= 1'b1;
      cpu_we <= 1'b1;
      cpu_addr <= 25'h0400000;
      for (i = 0; i < 12; i++) begin
         @(posedge clk);
         if (cpu_ready === 1'b1) acc++;
         else break;
      end
      cpu_valid <= 1'b0;
      check({i < 12, dma_ready}, 2'b10);
      if (i == 12) hang();
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         if (sel_cnt == acc && ext_chip_select_n === 4'hf) break;
      end
      if (i == 300) hang();
      check(sel_cnt, acc);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      reg_read(4'h0, rv);
      check(rv, 16'h0001);
      tally_and_finish();
   end
endmodule : nand_mode_chip_select_control_tb_top
